// >>> verilog/config_wakeup_sequencer.v
// Purpose: Restart pointer, option settings and wake-up sequencing
// Assumes: One clock, strobe register port, wake clock as enable pin
// Notes:   Wake clock and done pin are sampled by three-stage filters
//
// Function
// - First flash fetch starts at address zero
// - Hold 32-bit restart pointer from options
// - Warm reconfiguration fetches at previous restart pointer
// - Latch pointer on done rising; rewrites ignored
// - Master clock rate selectable, 1 MHz default
// - Done pin pull-up option, on by default
// - Readback lock: block, unlimited, or once
// - Readback output rerouted away from scan pin
// - Wake-up needs length count and end frame
// - Schedule done, set/reset release, output enable
// - External gate waits for done pin high
// - Gated mode rejects sequence writes above 7; a sequence set before the gate is kept
// - Phase codes: four, three and three bits
// - Counter clears on first wake clock edge
// - Four phases T0 to T3, shared allowed
// - Twenty-five orderings, sequence 21 default
// - Wake clock is config clock or internal
//
// The placing of the registers and the strobed register port were left to the implementer.
`include "config_wakeup_defines.vh"
`default_nettype none

module config_wakeup_sequencer #(
    parameter LEN_W = 24
) (
    input  wire              clock,
    input  wire              rstn,
    input  wire [3:0]        addr,
    input  wire [31:0]       wrData,
    input  wire              wrStrobe,
    input  wire              rdStrobe,
    output reg  [31:0]       readback_serial_out,
    input  wire              configClockTick,
    input  wire              internalClockTick,
    input  wire              slaveMode,
    input  wire [LEN_W-1:0]  lengthCount,
    input  wire              clockCountTick,
    input  wire              endFrameWritten,
    input  wire              initStatusIn,
    input  wire              warmReconfig,
    input  wire              reconfigStart,
    input  wire              doneIn,
    output wire              doneOut,
    output wire              doneOe,
    output wire              donePullUp,
    output wire              globalSetReset,
    output wire              globalOutputEnable,
    output wire [2:0]        masterClockRateSelect,
    output wire [31:0]       flashFetchAddr,
    input  wire              readbackRequest,
    output wire              readbackGrant,
    input  wire              readbackDataIn,
    output wire              readbackSerialOut,
    output wire              readbackAltOut,
    output wire              readbackInternal
);
    reg [1:0] rstSync;
    wire      rstnInt = rstSync[1];
    always @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            rstSync <= 2'h0;
        else
            rstSync <= {rstSync[0], 1'b1};
    end

    // Pin filters: a change counts when stages two and three agree
    reg [2:0] tickSync;
    reg [2:0] doneSync;
    reg [2:0] initSync;
    reg       wakeClkLvl_q;
    reg       donePin_q;
    reg       initHigh_q;
    always @(posedge clock or negedge rstnInt)
    begin
        if (!rstnInt)
        begin
            tickSync     <= 3'h0;
            doneSync     <= 3'h0;
            initSync     <= 3'h0;
            wakeClkLvl_q <= 1'b0;
            donePin_q    <= 1'b0;
            initHigh_q   <= 1'b0;
        end
        else
        begin
            tickSync <= {tickSync[1:0],
                         slaveMode ? configClockTick
                                   : internalClockTick};
            doneSync <= {doneSync[1:0], doneIn};
            initSync <= {initSync[1:0], initStatusIn};
            if (tickSync[1] == tickSync[2])
                wakeClkLvl_q <= tickSync[2];
            if (doneSync[1] == doneSync[2])
                donePin_q <= doneSync[2];
            if (initSync[1] == initSync[2])
                initHigh_q <= initSync[2];
        end
    end
    reg  wakeClkPrev_q;
    wire wakeEdge = wakeClkLvl_q & ~wakeClkPrev_q;

    // Option registers
    reg [31:0] restartPtr_q;
    reg [31:0] activePtr_q;
    reg [2:0]  rate_q;
    reg        pull_q;
    reg        gate_q;
    reg [1:0]  lock_q;
    reg [1:0]  route_q;
    reg [4:0]  seq_q;
    reg        readbackUsed_q;
    reg        seqError_q;

    wire [4:0] seqWr = wrData[4:0];
    wire seqOk = (seqWr != 5'h00) && (seqWr <= `MAX_SEQ) &&
                 (!gate_q || seqWr <= `MAX_GATED_SEQ);

    // Phase table: {done[3:0], gsr[2:0], goe[2:0]} per sequence
    reg [9:0] codes;
    always @*
    begin
        case (seq_q)
            5'h01: codes = {4'h0, 3'h1, 3'h1};
            5'h02: codes = {4'h0, 3'h2, 3'h2};
            5'h03: codes = {4'h0, 3'h3, 3'h3};
            5'h04: codes = {4'h0, 3'h2, 3'h1};
            5'h05: codes = {4'h0, 3'h3, 3'h1};
            5'h06: codes = {4'h0, 3'h3, 3'h1};
            5'h07: codes = {4'h0, 3'h2, 3'h1};
            5'h08: codes = {4'h1, 3'h2, 3'h2};
            5'h09: codes = {4'h1, 3'h3, 3'h3};
            5'h0a: codes = {4'h1, 3'h2, 3'h3};
            5'h0b: codes = {4'h1, 3'h3, 3'h2};
            5'h0c: codes = {4'h2, 3'h3, 3'h3};
            5'h0d: codes = {4'h2, 3'h1, 3'h1};
            5'h0e: codes = {4'h2, 3'h3, 3'h1};
            5'h0f: codes = {4'h2, 3'h3, 3'h1};
            5'h10: codes = {4'h2, 3'h3, 3'h3};
            5'h11: codes = {4'h2, 3'h1, 3'h3};
            5'h12: codes = {4'h2, 3'h1, 3'h1};
            5'h13: codes = {4'h3, 3'h2, 3'h2};
            5'h14: codes = {4'h3, 3'h1, 3'h1};
            5'h15: codes = {4'h3, 3'h2, 3'h1};
            5'h16: codes = {4'h3, 3'h2, 3'h1};
            5'h17: codes = {4'h3, 3'h2, 3'h2};
            5'h18: codes = {4'h3, 3'h1, 3'h2};
            5'h19: codes = {4'h3, 3'h1, 3'h1};
            default: codes = {4'h3, 3'h2, 3'h1};
        endcase
    end
    wire [3:0] doneCode = codes[9:6];
    wire [2:0] gsrCode  = codes[5:3];
    wire [2:0] goeCode  = codes[2:0];

    // Configuration-done detection
    reg [LEN_W-1:0] clkCount_q;
    reg             doneBit_q;
    always @(posedge clock or negedge rstnInt)
    begin
        if (!rstnInt)
        begin
            clkCount_q <= {LEN_W{1'b0}};
            doneBit_q  <= 1'b0;
        end
        else if (reconfigStart)
        begin
            clkCount_q <= {LEN_W{1'b0}};
            doneBit_q  <= 1'b0;
        end
        else
        begin
            if (initHigh_q && clockCountTick && clkCount_q != lengthCount)
                clkCount_q <= clkCount_q + 1'b1;
            if (clkCount_q == lengthCount && endFrameWritten)
                doneBit_q <= 1'b1;
        end
    end

    // Wake-up sequencer
    localparam ST_IDLE = 2'h0;
    localparam ST_ARM  = 2'h1;
    localparam ST_RUN  = 2'h2;
    localparam ST_HOLD = 2'h3;
    reg [1:0] state_q;
    reg [1:0] phase_q;
    reg       doneDrv_q;
    reg       gsrRel_q;
    reg       goeOn_q;
    wire      startOk = doneBit_q && (!gate_q || donePin_q);
    always @(posedge clock or negedge rstnInt)
    begin
        if (!rstnInt)
        begin
            state_q       <= ST_IDLE;
            phase_q       <= 2'h0;
            doneDrv_q     <= 1'b0;
            gsrRel_q      <= 1'b0;
            goeOn_q       <= 1'b0;
            wakeClkPrev_q <= 1'b0;
        end
        else
        begin
            wakeClkPrev_q <= wakeClkLvl_q;
            if (reconfigStart)
            begin
                state_q   <= ST_IDLE;
                phase_q   <= 2'h0;
                doneDrv_q <= 1'b0;
                gsrRel_q  <= 1'b0;
                goeOn_q   <= 1'b0;
            end
            else
            begin
                case (state_q)
                    ST_IDLE:
                    begin
                        // Gated wake: let go of done or it never rises
                        if (gate_q && doneBit_q)
                            doneDrv_q <= 1'b1;
                        if (startOk)
                            state_q <= ST_ARM;
                    end
                    ST_ARM:
                    begin
                        if (wakeEdge)
                        begin
                            phase_q <= 2'h0;
                            state_q <= ST_RUN;
                        end
                    end
                    ST_RUN:
                    begin
                        // Events fire when phase reaches their code
                        if ({2'h0, phase_q} == doneCode)
                            doneDrv_q <= 1'b1;
                        if ({1'b0, phase_q} == gsrCode)
                            gsrRel_q <= 1'b1;
                        if ({1'b0, phase_q} == goeCode)
                            goeOn_q <= 1'b1;
                        if (wakeEdge)
                        begin
                            if (phase_q == `PHASE_LAST)
                                state_q <= ST_HOLD;
                            else
                                phase_q <= phase_q + 2'h1;
                        end
                    end
                    ST_HOLD:
                    begin
                        doneDrv_q <= 1'b1;
                        gsrRel_q  <= 1'b1;
                        goeOn_q   <= 1'b1;
                    end
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end

    reg doneDrvPrev_q;
    reg warmSeen_q;
    always @(posedge clock or negedge rstnInt)
    begin
        if (!rstnInt)
        begin
            restartPtr_q   <= `RST_START_ADDR;
            activePtr_q    <= `RST_START_ADDR;
            doneDrvPrev_q  <= 1'b0;
            warmSeen_q     <= 1'b0;
            rate_q         <= `RST_RATE;
            pull_q         <= `RST_PULL;
            gate_q         <= `RST_GATE;
            lock_q         <= `RST_LOCK;
            route_q        <= 2'h0;
            seq_q          <= `RST_SEQ;
            readbackUsed_q <= 1'b0;
            seqError_q     <= 1'b0;
        end
        else
        begin
            doneDrvPrev_q <= doneDrv_q;
            // Latched copy protects the reconfiguration in flight
            if (doneDrv_q && !doneDrvPrev_q)
            begin
                activePtr_q <= restartPtr_q;
                warmSeen_q  <= 1'b1;
            end
            if (wrStrobe)
            begin
                case (addr)
                    `ADDR_RESTART_PTR: restartPtr_q <= wrData;
                    `ADDR_OPTIONS:
                    begin
                        rate_q  <= wrData[`OPT_RATE_LSB+2:`OPT_RATE_LSB];
                        pull_q  <= wrData[`OPT_PULL_BIT];
                        gate_q  <= wrData[`OPT_GATE_BIT];
                        if (wrData[`OPT_LOCK_LSB+1:`OPT_LOCK_LSB] != 2'h3)
                            lock_q <= wrData[`OPT_LOCK_LSB+1:`OPT_LOCK_LSB];
                        route_q <= wrData[`OPT_ROUTE_LSB+1:`OPT_ROUTE_LSB];
                    end
                    `ADDR_WAKE_SEQ:
                    begin
                        if (seqOk)
                            seq_q <= seqWr;
                        seqError_q <= !seqOk;
                    end
                    default: seqError_q <= seqError_q;
                endcase
            end
            if (readbackGrant && lock_q == `LOCK_ONCE)
                readbackUsed_q <= 1'b1;
        end
    end

    // Warm restart uses the pointer latched by the prior image
    assign flashFetchAddr = (warmReconfig && warmSeen_q) ? activePtr_q
                          : `RST_START_ADDR;
    assign masterClockRateSelect = rate_q;
    assign donePullUp = pull_q;
    // Done is open drain: pulled low until released
    assign doneOut = 1'b0;
    assign doneOe  = ~doneDrv_q;
    assign globalSetReset     = ~gsrRel_q;
    assign globalOutputEnable = goeOn_q;

    assign readbackGrant = readbackRequest &&
        (lock_q == `LOCK_UNLIMITED ||
         (lock_q == `LOCK_ONCE && !readbackUsed_q));
    wire rbData = readbackGrant & readbackDataIn;
    assign readbackSerialOut = (route_q == 2'h0) & rbData;
    assign readbackAltOut    = (route_q == 2'h1) & rbData;
    assign readbackInternal  = (route_q == 2'h2) & rbData;

    always @(posedge clock or negedge rstnInt)
    begin
        if (!rstnInt)
            readback_serial_out <= 32'h00000000;
        else if (rdStrobe)
        begin
            case (addr)
                `ADDR_RESTART_PTR: readback_serial_out <= restartPtr_q;
                `ADDR_OPTIONS:
                    readback_serial_out <= {23'h000000, route_q, lock_q, gate_q,
                               pull_q, rate_q};
                `ADDR_WAKE_SEQ: readback_serial_out <= {27'h0000000, seq_q};
                `ADDR_STATUS:
                    readback_serial_out <= {22'h000000, seqError_q, readbackUsed_q,
                               state_q, phase_q, goeOn_q, gsrRel_q,
                               doneDrv_q, doneBit_q};
                `ADDR_ACTIVE_PTR: readback_serial_out <= activePtr_q;
                default: readback_serial_out <= 32'h00000000;
            endcase
        end
        else
            readback_serial_out <= 32'h00000000;
    end
endmodule

`default_nettype wire

// >>> verilog/config_wakeup_defines.vh
// Purpose: Constants for the post-configuration wake-up sequencer
// Assumes: Included by config_wakeup_sequencer.v, the assertion module and the bench
// Notes:   Offsets of the option registers; wake-up codes; reset values
`ifndef CONFIG_WAKEUP_DEFINES_VH
`define CONFIG_WAKEUP_DEFINES_VH

`define ADDR_RESTART_PTR   4'h0
`define ADDR_OPTIONS       4'h1
`define ADDR_WAKE_SEQ      4'h2
`define ADDR_STATUS        4'h3
`define ADDR_ACTIVE_PTR    4'h4
`define ADDR_CONTROL       4'h5

`define OPT_RATE_LSB       0
`define OPT_PULL_BIT       3
`define OPT_GATE_BIT       4
`define OPT_LOCK_LSB       5
`define OPT_ROUTE_LSB      7

`define RST_START_ADDR     32'h00000000
`define RST_RATE           3'h0
`define RST_PULL           1'b1
`define RST_GATE           1'b0
`define RST_LOCK           2'h0
`define RST_SEQ            5'h15
`define MAX_SEQ            5'h19
`define MAX_GATED_SEQ      5'h07

`define LOCK_BLOCK         2'h0
`define LOCK_UNLIMITED     2'h1
`define LOCK_ONCE          2'h2

`define PHASE_LAST         2'h3

`endif

// >>> bench/config_wakeup_sequencer_asserts.sv
// Purpose: Port-level checks for the wake-up sequencer
// Assumes: One clock domain, rstn active low
// Notes:   Hold checks skip a few cycles after a restart pulse
`include "config_wakeup_defines.vh"
`default_nettype none
module config_wakeup_sequencer_asserts (
    input wire logic        clock,
    input wire logic        rstn,
    input wire logic [3:0]  addr,
    input wire logic [31:0] wrData,
    input wire logic        wrStrobe,
    input wire logic        rdStrobe,
    input wire logic [31:0] readback_serial_out,
    input wire logic        endFrameWritten,
    input wire logic        warmReconfig,
    input wire logic        reconfigStart,
    input wire logic        doneOe,
    input wire logic        donePullUp,
    input wire logic        globalSetReset,
    input wire logic        globalOutputEnable,
    input wire logic [2:0]  masterClockRateSelect,
    input wire logic [31:0] flashFetchAddr,
    input wire logic        readbackGrant,
    input wire logic        readbackSerialOut,
    input wire logic        readbackAltOut,
    input wire logic        readbackInternal
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] restartHist_q;
    logic       quiet;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // Registered outputs may lag a restart pulse
    always_ff @(posedge clock or negedge rstn)
        if (!rstn)
            restartHist_q <= 3'h0;
        else
            restartHist_q <= {restartHist_q[1:0], reconfigStart};
    assign quiet = !reconfigStart && restartHist_q == 3'h0;
    sequence sOptWrite;
        wrStrobe && addr == `ADDR_OPTIONS;
    endsequence
    sequence sColdRun;
        !warmReconfig [*2];
    endsequence
    a_readback_serial_out_idle: assert property (!rdStrobe |=> readback_serial_out == 32'h0)
        else $error("read data not idle");
    a_rate_write: assert property (sOptWrite |=>
        masterClockRateSelect == $past(wrData[2:0]))
        else $error("clock rate not applied");
    a_pull_write: assert property (sOptWrite |=>
        donePullUp == $past(wrData[`OPT_PULL_BIT]))
        else $error("pull-up not applied");
    a_fetch_cold: assert property (sColdRun |->
        flashFetchAddr == 32'h0)
        else $error("cold fetch not at zero");
    a_goe_held: assert property (globalOutputEnable && quiet |=>
        globalOutputEnable)
        else $error("output enable dropped");
    a_gsr_held: assert property (!globalSetReset && quiet |=>
        !globalSetReset)
        else $error("set/reset reasserted");
    a_done_held: assert property (!doneOe && quiet |=> !doneOe)
        else $error("done pulled low again");
    a_wake_cause: assert property ($rose(globalOutputEnable)
        || $fell(globalSetReset) |-> endFrameWritten)
        else $error("wake event without end frame");
    a_readback_gate: assert property (!readbackGrant |->
        !(readbackSerialOut || readbackAltOut || readbackInternal))
        else $error("readback data without grant");
    a_route_one: assert property ($onehot0({readbackSerialOut,
        readbackAltOut, readbackInternal}))
        else $error("readback on two routes");
endmodule
bind config_wakeup_sequencer config_wakeup_sequencer_asserts i_asserts (
    .clock, .rstn, .addr, .wrData, .wrStrobe, .rdStrobe, .readback_serial_out,
    .endFrameWritten, .warmReconfig, .reconfigStart, .doneOe, .donePullUp,
    .globalSetReset, .globalOutputEnable, .masterClockRateSelect,
    .flashFetchAddr, .readbackGrant, .readbackSerialOut, .readbackAltOut,
    .readbackInternal
);
`default_nettype wire

// >>> bench/done_line_peer.sv
// Purpose: Peer device sharing the done and init lines
// Assumes: Open-drain wiring; only the sequencer supplies a pull-up
// Notes:   An undriven, unpulled line toggles to expose a missing pull
`default_nettype none
module done_line_peer (
    input  wire logic clock,
    input  wire logic doneOe,
    input  wire logic donePullUp,
    input  wire logic holdDone,
    input  wire logic holdInit,
    output var  logic doneLine,
    output var  logic initLine
);
    timeunit 1ns;
    timeprecision 1ps;
    logic floatLevel = 1'b0;
    always @(posedge clock)
        floatLevel <= ~floatLevel;
    // Wired-AND of both parties
    always_comb
        doneLine = (doneOe || holdDone) ? 1'b0 : donePullUp | floatLevel;
    always_comb
        initLine = !holdInit;
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
// Purpose: Self-checking bench for the wake-up sequencer
// Assumes: Bench drives both wake clock pins as slow levels
// Notes:   Xorshift stimulus; all 25 orderings are run
`include "config_wakeup_defines.vh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 1'b0, rstn = 1'b0, slaveMode = 1'b0;
    logic        wrStrobe = 1'b0, rdStrobe = 1'b0, holdDone = 1'b0;
    logic        configClockTick = 1'b0, internalClockTick = 1'b0;
    logic        clockCountTick = 1'b0, endFrameWritten = 1'b0;
    logic        warmReconfig = 1'b0, reconfigStart = 1'b0;
    logic        readbackRequest = 1'b0, readbackDataIn = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [7:0]  lengthCount = 8'h0;
    logic [31:0] wrData = 32'h0, seed = 32'hdabfebd4, ptr, v;
    logic [31:0] readback_serial_out, flashFetchAddr;
    logic [2:0]  masterClockRateSelect;
    logic        doneIn, initStatusIn, doneOe, donePullUp, readbackGrant;
    logic        globalSetReset, globalOutputEnable, readbackSerialOut;
    logic        readbackAltOut, readbackInternal, doneOut;
    int          mismatches = 0, totalChecks = 0, edges, tG, tS, tD;
    // Phase of done, enable and reset release for orderings 1..25
    string       dP = "0000000111122222223333333";
    string       gP = "1231111233231113312111221";
    string       sP = "1232332232331333112122211";
    config_wakeup_sequencer #(.LEN_W(8)) i_config_wakeup_sequencer (
        .clock, .rstn, .addr, .wrData, .wrStrobe, .rdStrobe, .readback_serial_out,
        .configClockTick, .internalClockTick, .slaveMode, .lengthCount,
        .clockCountTick, .endFrameWritten, .initStatusIn, .warmReconfig,
        .reconfigStart, .doneIn, .doneOut, .doneOe, .donePullUp,
        .globalSetReset, .globalOutputEnable, .masterClockRateSelect,
        .flashFetchAddr, .readbackRequest, .readbackGrant, .readbackDataIn,
        .readbackSerialOut, .readbackAltOut, .readbackInternal
    );
    done_line_peer i_done_line_peer (.clock, .doneOe, .donePullUp,
        .holdDone, .holdInit(1'b0), .doneLine(doneIn), .initLine(initStatusIn));
    always #4 clock = ~clock;
    always @(posedge globalOutputEnable)
        tG = edges;
    always @(negedge globalSetReset)
        tS = edges;
    always @(negedge doneOe)
        tD = edges;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [31:0] opt(input logic [2:0] r, input logic p,
        input logic g, input logic [1:0] l, input logic [1:0] rt);
        return {23'h0, rt, l, g, p, r};
    endfunction
    // Expected count of wake edges seen when an event fires
    function automatic int ph(input string t, input int s);
        return t[s-1] - 8'd48 + 1;
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: %h not %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", totalChecks, mismatches);
        if (mismatches == 0 && totalChecks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        @(posedge clock);
        wrStrobe <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [3:0] a);
        addr <= a;
        rdStrobe <= 1'b1;
        @(posedge clock);
        rdStrobe <= 1'b0;
        @(negedge clock);
        v = readback_serial_out;
        @(posedge clock);
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
        rd(a);
        check(v, e);
    endtask
    task automatic arm(input int s, input logic g, input logic h);
        int n;
        n = rnd() % 8 + 1;
        wr(`ADDR_OPTIONS, opt(3'h0, 1'b1, g, `LOCK_UNLIMITED, 2'h0));
        wr(`ADDR_WAKE_SEQ, s);
        ptr = rnd();
        wr(`ADDR_RESTART_PTR, ptr);
        reconfigStart <= 1'b1;
        // Park both wake pins low so the first pulse makes an edge
        configClockTick <= 1'b0;
        internalClockTick <= 1'b0;
        endFrameWritten <= 1'b0;
        holdDone <= h;
        slaveMode <= s[0];
        lengthCount <= n[7:0];
        @(posedge clock);
        reconfigStart <= 1'b0;
        repeat (n)
        begin
            clockCountTick <= 1'b1;
            @(posedge clock);
            clockCountTick <= 1'b0;
            @(posedge clock);
        end
        endFrameWritten <= 1'b1;
        repeat (8) @(posedge clock);
    endtask
    // The idle wake pin toggles twice as fast to catch a wrong selection
    task automatic pulses(input int n);
        edges = 0;
        tG = -1;
        tS = -1;
        tD = -1;
        repeat (n)
        begin
            edges++;
            for (int c = 0; c < 16; c++)
            begin
                configClockTick <= slaveMode ? c < 8 : c[2];
                internalClockTick <= slaveMode ? c[2] : c < 8;
                @(posedge clock);
            end
        end
    endtask
    task automatic verify(input int s);
        check(tD, ph(dP, s));
        check(tG, ph(gP, s));
        check(tS, ph(sP, s));
        check({doneOut, doneOe, globalSetReset, globalOutputEnable},
            4'h1);
        check(doneIn, !holdDone);
        wr(`ADDR_RESTART_PTR, rnd());
        warmReconfig <= 1'b1;
        repeat (2) @(posedge clock);
        check(flashFetchAddr, ptr);
        rdchk(`ADDR_ACTIVE_PTR, ptr);
        warmReconfig <= 1'b0;
    endtask
    task automatic rb(input logic [1:0] l, input logic [1:0] rt,
        input logic e);
        if (l != 2'h3)
            wr(`ADDR_OPTIONS, opt(3'h0, 1'b1, 1'b0, l, rt));
        readbackDataIn <= 1'b1;
        readbackRequest <= 1'b1;
        @(negedge clock);
        check(readbackGrant, e);
        check({readbackInternal, readbackAltOut, readbackSerialOut},
            e ? 3'h1 << rt : 3'h0);
        @(posedge clock);
        readbackRequest <= 1'b0;
        @(posedge clock);
    endtask
    initial
    begin
        repeat (4) @(posedge clock);
        rstn <= 1'b1;
        repeat (3) @(posedge clock);
        check(flashFetchAddr, 32'h0);
        check({donePullUp, masterClockRateSelect}, 4'h8);
        rdchk(`ADDR_OPTIONS, 32'h8);
        rdchk(`ADDR_WAKE_SEQ, 32'd21);
        rdchk(`ADDR_RESTART_PTR, 32'h0);
        rdchk(4'hf, 32'h0);
        wr(`ADDR_WAKE_SEQ, 32'd0);
        wr(`ADDR_WAKE_SEQ, 32'd26);
        rdchk(`ADDR_WAKE_SEQ, 32'd21);
        for (int r = 0; r < 8; r++)
        begin
            wr(`ADDR_OPTIONS, opt(r[2:0], r[0], 1'b0, 2'h0, 2'h0));
            check({donePullUp, masterClockRateSelect},
                {r[0], r[2:0]});
        end
        for (int s = 1; s <= 25; s++)
        begin
            arm(s, 1'b0, rnd() > 32'h7fffffff);
            pulses(5);
            verify(s);
        end
        arm(4, 1'b1, 1'b1);
        wr(`ADDR_WAKE_SEQ, 32'd8);
        rdchk(`ADDR_WAKE_SEQ, 32'd4);
        rd(`ADDR_STATUS);
        check(v[9], 1'b1);
        pulses(5);
        check(globalOutputEnable, 1'b0);
        holdDone <= 1'b0;
        repeat (8) @(posedge clock);
        pulses(5);
        check({doneOe, globalSetReset, globalOutputEnable},
            3'h1);
        rb(`LOCK_BLOCK, 2'h0, 1'b0);
        for (int k = 0; k < 3; k++)
            rb(`LOCK_UNLIMITED, k[1:0], 1'b1);
        rb(`LOCK_ONCE, 2'h1, 1'b1);
        rb(2'h3, 2'h1, 1'b0);
        report_and_stop();
    end
    // Generous bound: the sequence needs under 5000 cycles
    initial
    begin
        #200000;
        mismatches++;
        report_and_stop();
    end
endmodule
`default_nettype wire
